// ===== rtl/bcw_consts.vh
// Constants for the self-test clock, bus level and watchdog register bank.
// Assumes byte-wide registers at byte offsets on a plain strobe port.
`ifndef BCW_CONSTS_VH
`define BCW_CONSTS_VH
`define BCW_ADDR_W 8
`define BCW_OFF_SELF_TEST 8'h14
`define BCW_OFF_LEVEL_SEL 8'h15
`define BCW_OFF_WATCHDOG 8'h16
`define BCW_OFF_IRQ_STATUS 8'h17
`define BCW_OFF_IRQ_MASK 8'h18
`define BCW_OFF_STATUS 8'h19
`define BCW_OFF_RESET 8'h1A
`define BCW_RST_SELF_TEST 8'h00
`define BCW_RST_LEVEL_SEL 8'h01
`define BCW_RST_WATCHDOG 8'hFE
`define BCW_CODE_LEVEL_SET 8'hB5
`define BCW_CODE_LEVEL_CLR 8'hB6
`define BCW_BIT_SELF_TEST_EN 0
`define BCW_BIT_WD_DISABLE 0
`define BCW_SRC_EXT_PIXEL 3'h0
`define BCW_SRC_OSC_25 3'h1
`define BCW_SRC_OSC_33 3'h2
`define BCW_SRC_OSC_50 3'h3
`define BCW_SRC_OSC_100 3'h4
`define BCW_SRC_NONE 3'h7
`define BCW_CLK_MHZ 100
`define BCW_WD_STEP_MS 2
`define BCW_WD_STEP_CYC (`BCW_WD_STEP_MS * 1000 * `BCW_CLK_MHZ)
`define BCW_IRQ_TIMEOUT 0
`define BCW_IRQ_DONE 1
`define BCW_IRQ_W 2
`endif

// ===== rtl/bcw_reg_bank.v
// Register bank for self-test clock select, control bus level select and the
// control channel watchdog. Assumes one 100 MHz clock, a strobe register port
// with read data one cycle after the read strobe, and transaction start and
// done pulses from logic on the same clock.
// Function
// - Without a video clock and with the oscillator frame enabled, codes 00/01 pick 50 MHz, 10 picks 100 MHz, 11 picks 25 MHz.
// - In self-test mode the source field picks the pixel clock for 00, 33 MHz for 01 and 100 MHz for 1x.
// - Bit 0 of the self-test register enables self-test when set and resets cleared.
// - At power-up the strap is sampled: low gives 3.3V signaling, high gives 1.8V.
// - Either digital reset command forces the level selection back to 3.3V.
// - Reading the level register gives 0 for 1.8V and 1 for 3.3V.
// - Of the writes to the level register, only the whole-byte codes B5 (set) and B6 (clear) change the level selection.
// - A transaction not finished within the programmed interval is aborted.
// - Watchdog bits 7:1 count in 2 ms steps and the register resets to FE.
// - Watchdog bit 0 cleared enables the watchdog, set disables it.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
`include "bcw_consts.vh"

module bcw_reg_bank #(
   parameter STEP_CYC = `BCW_WD_STEP_CYC
) (
   input wire i_ref_clk,
   input wire i_nrst,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire i_strap_level,
   input wire i_video_clk_present,
   input wire i_osc_frame_en,
   input wire i_txn_start,
   input wire i_txn_done,
   output reg [7:0] o_rdata,
   output reg [2:0] o_clk_src,
   output reg o_self_test_en,
   output reg o_bus_level_select,
   output reg o_txn_abort,
   output reg o_txn_busy,
   output reg o_irq
);

////////////////////////////////////////////////////////////////////////////////
// Source decode, used for the live output and the status readback.

   function [2:0] bcw_src;
      input [1:0] code;
      input self_test;
      input video;
      input osc_en;
      begin
         if (self_test) begin
            if (code[1]) begin
               bcw_src = `BCW_SRC_OSC_100;
            end else if (code[0]) begin
               bcw_src = `BCW_SRC_OSC_33;
            end else begin
               bcw_src = `BCW_SRC_EXT_PIXEL;
            end
         end else if (!video && osc_en) begin
            case (code)
               2'h2: bcw_src = `BCW_SRC_OSC_100;
               2'h3: bcw_src = `BCW_SRC_OSC_25;
               default: bcw_src = `BCW_SRC_OSC_50;
            endcase
         end else begin
            bcw_src = `BCW_SRC_NONE;
         end
      end
   endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers. First stages feed only the second stages.

   reg strap_s1;
   reg strap_s2;
   reg video_s1;
   reg video_s2;

   // Strap and video detect come from outside the clock domain.
   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         strap_s1 <= 1'b0;
         strap_s2 <= 1'b0;
         video_s1 <= 1'b0;
         video_s2 <= 1'b0;
      end else begin
         strap_s1 <= i_strap_level;
         strap_s2 <= strap_s1;
         video_s1 <= i_video_clk_present;
         video_s2 <= video_s1;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Registers.

   reg [1:0] src_code;
   reg [6:0] wd_value;
   reg wd_disable;
   reg [1:0] irq_status;
   reg [1:0] irq_mask;
   reg strap_taken;
   reg [2:0] strap_wait;
   wire wr_st = i_wr && (i_addr == `BCW_OFF_SELF_TEST);
   wire wr_lv = i_wr && (i_addr == `BCW_OFF_LEVEL_SEL);
   wire wr_wd = i_wr && (i_addr == `BCW_OFF_WATCHDOG);
   wire wr_is = i_wr && (i_addr == `BCW_OFF_IRQ_STATUS);
   wire wr_im = i_wr && (i_addr == `BCW_OFF_IRQ_MASK);
   wire wr_rs = i_wr && (i_addr == `BCW_OFF_RESET) && (i_wdata[1:0] != 2'h0);
   wire [1:0] irq_evt;

   // The strap is taken a few cycles after reset release so the
   // synchroniser has settled; a level reset or a code write afterwards wins.
   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         src_code <= 2'h0;
         o_self_test_en <= 1'b0;
         o_bus_level_select <= 1'b1;
         wd_value <= 7'h7F;
         wd_disable <= 1'b0;
         irq_mask <= 2'h0;
         strap_taken <= 1'b0;
         strap_wait <= 3'h0;
      end else begin
         if (!strap_taken) begin
            strap_wait <= strap_wait + 3'h1;
            if (strap_wait == 3'h3) begin
               strap_taken <= 1'b1;
               o_bus_level_select <= ~strap_s2;
            end
         end
         if (wr_st) begin
            src_code <= i_wdata[2:1];
            o_self_test_en <= i_wdata[`BCW_BIT_SELF_TEST_EN];
         end
         if (wr_lv && i_wdata == `BCW_CODE_LEVEL_SET) begin
            o_bus_level_select <= 1'b1;
         end else if (wr_lv && i_wdata == `BCW_CODE_LEVEL_CLR) begin
            o_bus_level_select <= 1'b0;
         end
         if (wr_rs) begin
            o_bus_level_select <= 1'b1;
            strap_taken <= 1'b1;
         end
         if (wr_wd) begin
            wd_value <= i_wdata[7:1];
            wd_disable <= i_wdata[`BCW_BIT_WD_DISABLE];
         end
         if (wr_im) begin
            irq_mask <= i_wdata[1:0];
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Watchdog. A step prescaler makes a 2 ms enable; the step counter compares
// against the programmed value. A zero value times out on the first step.

   reg [31:0] pre_cnt;
   reg [6:0] step_cnt;
   wire step_tick = (pre_cnt == STEP_CYC - 1);
   wire expired = step_tick && (step_cnt + 7'h1 >= wd_value);

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pre_cnt <= 32'h0;
         step_cnt <= 7'h0;
         o_txn_busy <= 1'b0;
         o_txn_abort <= 1'b0;
      end else begin
         o_txn_abort <= 1'b0;
         if (i_txn_start) begin
            o_txn_busy <= 1'b1;
            pre_cnt <= 32'h0;
            step_cnt <= 7'h0;
         end else if (o_txn_busy && i_txn_done) begin
            o_txn_busy <= 1'b0;
         end else if (o_txn_busy && !wd_disable) begin
            if (expired) begin
               o_txn_busy <= 1'b0;
               o_txn_abort <= 1'b1;
            end else if (step_tick) begin
               pre_cnt <= 32'h0;
               step_cnt <= step_cnt + 7'h1;
            end else begin
               pre_cnt <= pre_cnt + 32'h1;
            end
         end
      end
   end

   assign irq_evt[`BCW_IRQ_TIMEOUT] = o_txn_abort;
   assign irq_evt[`BCW_IRQ_DONE] = o_txn_busy && i_txn_done && !i_txn_start;

////////////////////////////////////////////////////////////////////////////////
// Sticky interrupt status, write one to clear; a new event beats the clear.

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_status <= 2'h0;
         o_irq <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~(wr_is ? i_wdata[1:0] : 2'h0)) | irq_evt;
         o_irq <= |(((irq_status & ~(wr_is ? i_wdata[1:0] : 2'h0)) | irq_evt) & irq_mask);
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Clock source output and read port. Unmapped addresses read zero.

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_clk_src <= `BCW_SRC_NONE;
         o_rdata <= 8'h00;
      end else begin
         o_clk_src <= bcw_src(src_code, o_self_test_en, video_s2, i_osc_frame_en);
         o_rdata <= 8'h00;
         if (i_rd) begin
            case (i_addr)
               `BCW_OFF_SELF_TEST: o_rdata <= {5'h00, src_code, o_self_test_en};
               `BCW_OFF_LEVEL_SEL: o_rdata <= {7'h00, o_bus_level_select};
               `BCW_OFF_WATCHDOG: o_rdata <= {wd_value, wd_disable};
               `BCW_OFF_IRQ_STATUS: o_rdata <= {6'h00, irq_status};
               `BCW_OFF_IRQ_MASK: o_rdata <= {6'h00, irq_mask};
               `BCW_OFF_STATUS: o_rdata <= {3'h0, o_clk_src, video_s2, o_txn_busy};
               default: o_rdata <= 8'h00;
            endcase
         end
      end
   end

endmodule

// ===== verif/bcw_reg_bank_assertions.sv
// Port assertions for the register bank.
// Assumes a bind onto bcw_reg_bank on its one clock.
`timescale 1ns/1ns
module bcw_chk (
   input wire i_ref_clk,
   input wire i_nrst,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire i_txn_start,
   input wire [7:0] o_rdata,
   input wire o_self_test_en,
   input wire o_bus_level_select,
   input wire o_txn_abort,
   input wire o_txn_busy
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   // Writes to the level register; only whole-byte codes may move it.
   wire wl = i_wr && i_addr == 8'h15;
   property p_set; wl && i_wdata == 8'hB5 |=> o_bus_level_select; endproperty
   a_set: assert property (p_set) else $error("no set");
   property p_clr; wl && i_wdata == 8'hB6 |=> !o_bus_level_select; endproperty
   a_clr: assert property (p_clr) else $error("no clear");
   property p_rc; i_wr && i_addr == 8'h1A && i_wdata[1:0] != 2'b00 |=> o_bus_level_select;
   endproperty
   a_rc: assert property (p_rc) else $error("no 3.3V");
   property p_rl; i_rd && i_addr == 8'h15 |=> o_rdata == {7'h00, o_bus_level_select};
   endproperty
   a_rl: assert property (p_rl) else $error("bad level read");
   property p_st; i_wr && i_addr == 8'h14 && i_wdata[0] |-> ##[1:2] o_self_test_en;
   endproperty
   a_st: assert property (p_st) else $error("no self-test");
   property p_bz; i_txn_start |=> o_txn_busy; endproperty
   a_bz: assert property (p_bz) else $error("no busy");
   property p_ab; o_txn_abort |-> !o_txn_busy && $past(o_txn_busy); endproperty
   a_ab: assert property (p_ab) else $error("stray abort");
   property p_ap; o_txn_abort |=> !o_txn_abort; endproperty
   a_ap: assert property (p_ap) else $error("long abort");
endmodule
bind bcw_reg_bank bcw_chk u_chk (.i_ref_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd,
   .i_txn_start, .o_rdata, .o_self_test_en, .o_bus_level_select, .o_txn_abort, .o_txn_busy);

// ===== verif/bcw_far_side.sv
// Remote end of the control channel: opens a transaction, ends it late or never.
// Assumes the bench pulses i_go for one cycle with i_lat set.
`timescale 1ns/1ns
module bcw_far_side (
   input wire i_ref_clk,
   input wire i_go,
   input wire [7:0] i_lat,
   output reg o_start = 1'b0,
   output reg o_done = 1'b0
);
   integer cnt = 0;
   // A latency of zero is a stalled remote that never completes.
   always @(posedge i_ref_clk) begin
      o_start <= i_go;
      o_done <= cnt == 1;
      cnt <= i_go ? i_lat : cnt > 0 ? cnt - 1 : 0;
   end
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the register bank.
// Assumes the bank, checker and far-side model are compiled first.
`timescale 1ns/1ns
`include "bcw_consts.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %s exp %0h got %0h", n, e, g); end end
module testbench;
   reg i_ref_clk = 0, i_nrst = 0, wr = 0, rd = 0, strap = 0, go = 0;
   reg [7:0] ad = 8'h00, wd = 8'h00, lat = 8'h00, d;
   reg [31:0] rs = 32'h00014D22;
   wire [7:0] rdata;
   wire [2:0] src;
   wire st, lvl, abt, busy, irq, ts, td;
   integer miscompares = 0, checked = 0, cyc = 0, ab = 0, m_lvl, i, n;
   bcw_reg_bank #(.STEP_CYC(8)) i_dut (.i_ref_clk, .i_nrst, .i_addr(ad), .i_wdata(wd),
      .i_wr(wr), .i_rd(rd), .i_strap_level(strap), .i_video_clk_present(1'b0),
      .i_osc_frame_en(1'b1), .i_txn_start(ts), .i_txn_done(td), .o_rdata(rdata),
      .o_clk_src(src), .o_self_test_en(st), .o_bus_level_select(lvl), .o_txn_abort(abt),
      .o_txn_busy(busy), .o_irq(irq));
   bcw_far_side i_far (.i_ref_clk, .i_go(go), .i_lat(lat), .o_start(ts), .o_done(td));
   // Clock, a cycle ceiling against hangs, and a tally of aborts.
   always #5 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      ab <= ab + abt;
      if (cyc == 5000) begin
         miscompares++;
         tally_and_finish;
      end
   end
   function [31:0] xs(input [31:0] x);
      xs = x ^ (x << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction
   // One bus cycle; read data is taken in the cycle after the strobe.
   task acc(input w, input [7:0] a, input [7:0] v);
      @(posedge i_ref_clk);
      wr <= w;
      rd <= !w;
      ad <= a;
      wd <= v;
      @(posedge i_ref_clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task pulse(input [7:0] l);
      @(posedge i_ref_clk);
      lat <= l;
      go <= 1'b1;
      @(posedge i_ref_clk);
      go <= 1'b0;
   endtask
   // The strap is set two cycles before reset lifts, so its sample is certain.
   task rst(input s);
      @(posedge i_ref_clk);
      i_nrst <= 1'b0;
      strap <= s;
      repeat (2) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      repeat (8) @(posedge i_ref_clk);
      m_lvl = !s;
   endtask
   task tally_and_finish;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      rst(1'b0);
      acc(0, `BCW_OFF_WATCHDOG, 8'h00);
      `CHK("wd", 8'hFE, d)
      // Random bytes into the level register, both codes mixed in.
      for (i = 0; i < 24; i++) begin
         rs = xs(rs);
         n = i % 4 == 1 ? 8'hB5 : i % 4 == 3 ? 8'hB6 : rs[7:0];
         if (n == 8'hB5 || n == 8'hB6)
            m_lvl = n == 8'hB5;
         acc(1, `BCW_OFF_LEVEL_SEL, n[7:0]);
         acc(0, `BCW_OFF_LEVEL_SEL, 8'h00);
         `CHK("lvl", m_lvl[7:0], d)
      end
      acc(1, `BCW_OFF_RESET, 8'h01);
      acc(0, `BCW_OFF_LEVEL_SEL, 8'h00);
      `CHK("lvl_rst", 8'h01, d)
      $display("level test done");
      for (i = 0; i < 8; i++) begin
         acc(1, `BCW_OFF_SELF_TEST, i[7:0]);
         #31 n = i[0] ? (i[2] ? 4 : i[1] ? 2 : 0) : (i[2:1] == 2 ? 4 : i[2:1] == 3 ? 1 : 3);
         `CHK("src", n[2:0], src)
         `CHK("st", i[0], st)
      end
      $display("source test done");
      acc(1, `BCW_OFF_IRQ_MASK, 8'h01);
      acc(1, `BCW_OFF_WATCHDOG, 8'h02);
      pulse(8'h00);
      n = cyc;
      wait (abt);
      `CHK("abort_at", 1'b1, cyc - n >= 8 && cyc - n <= 12)
      acc(0, `BCW_OFF_IRQ_STATUS, 8'h00);
      `CHK("irq", 2'b11, {d[0], irq})
      acc(1, `BCW_OFF_IRQ_STATUS, 8'h01);
      #11 `CHK("irq_clr", 1'b0, irq)
      n = ab;
      pulse(8'h02);
      #201 `CHK("done_ok", n, ab)
      `CHK("idle", 1'b0, busy)
      acc(0, `BCW_OFF_IRQ_STATUS, 8'h00);
      `CHK("irq_done", 2'b10, d[1:0])
      acc(1, `BCW_OFF_WATCHDOG, 8'h03);
      pulse(8'h00);
      #301 `CHK("wd_off", n, ab)
      $display("watchdog test done");
      rst(1'b1);
      acc(0, `BCW_OFF_LEVEL_SEL, 8'h00);
      `CHK("strap", 8'h00, d)
      $display("strap test done");
      tally_and_finish;
   end
endmodule
